// ===== core/tafs_auth_fsm.sv
// Purpose: Authorization state machine of an access terminal
// Assumes: Message decoder on clk_sys delivers one-cycle event pulses
// Notes:   Traffic-key machines and crypto live outside this block
`timescale 1ns/1ns
`include "tafs_map.svh"
module tafs_auth_fsm #(
  parameter int          NTEK     = `TAFS_NTEK,
  parameter int          SEC_W    = `TAFS_SEC_W,
  parameter int          AK_W     = `TAFS_AK_W,
  parameter int unsigned TICK_CYC =
    (`TAFS_TICK_PERIOD_S * `TAFS_NS_PER_S) / `TAFS_CLK_PERIOD_NS
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  rx_auth_cmd,
  input  wire logic                  rx_auth_reject,
  input  wire logic                  reject_perm,
  input  wire logic                  rx_auth_reply,
  input  wire logic [AK_W-1:0]       reply_ak,
  input  wire logic [SEC_W-1:0]      reply_ak_life,
  input  wire logic [NTEK-1:0]       reply_said_list,
  input  wire logic                  rx_auth_invalid,
  input  wire logic                  tek_auth_fail,
  input  wire logic                  inv_src_valid,
  input  wire logic [$clog2(NTEK)-1:0] inv_src_id,
  input  wire logic                  reauth_req,
  input  wire logic                  rx_mgmt_msg,
  input  wire logic [SEC_W-1:0]      cfg_auth_wait_s,
  input  wire logic [SEC_W-1:0]      cfg_reauth_wait_s,
  input  wire logic [SEC_W-1:0]      cfg_grace_s,
  input  wire logic [SEC_W-1:0]      cfg_reject_wait_s,
  output tafs_pkg::tafs_state_t      state_q,
  output logic                       tx_mfr_info_q,
  output logic                       tx_auth_req_q,
  output logic                       mgmt_resp_q,
  output logic                       traffic_en_q,
  output logic                       trap_term_q,
  output logic [AK_W-1:0]            ak_q,
  output logic [NTEK-1:0]            tek_active_q,
  output logic [NTEK-1:0]            tek_stop_q,
  output logic [NTEK-1:0]            tek_authorized_q,
  output logic [NTEK-1:0]            tek_pend_q,
  output logic [NTEK-1:0]            tek_comp_q
);
  import tafs_pkg::*;

  // One-hot select of the key machine blamed for an invalid event
  function automatic logic [NTEK-1:0] sid_onehot(
    input logic                    vld,
    input logic [$clog2(NTEK)-1:0] id
  );
    logic [NTEK-1:0] oh;
    oh = '0;
    if (vld)
      oh[id] = 1'b1;
    return oh;
  endfunction

  logic        tick;
  logic        retry_run;
  logic        retry_exp;
  logic        rejw_run;
  logic        rejw_exp;
  logic        grace_run;
  logic        grace_exp;
  tafs_state_t state_d;

  // State decode
  wire in_start = (state_q == TAFS_START);
  wire in_aw    = (state_q == TAFS_AUTH_WAIT);
  wire in_auth  = (state_q == TAFS_AUTHORIZED);
  wire in_rw    = (state_q == TAFS_REAUTH_WT);
  wire in_rjw   = (state_q == TAFS_REJECT_WT);
  wire in_term  = (state_q == TAFS_TERMINATED);

  // Invalid event from either source; both mean lost key sync
  wire ev_inv = rx_auth_invalid | tek_auth_fail;

  // Event qualification; reject beats reply beats retry timeout
  wire do_cmd    = in_start & rx_auth_cmd;
  wire rej_np    = rx_auth_reject & ~reject_perm;
  wire rej_p     = rx_auth_reject & reject_perm;
  wire do_np_aw  = in_aw & rej_np;
  wire do_np_rw  = in_rw & rej_np;
  wire do_p_aw   = in_aw & rej_p;
  wire do_p_rw   = in_rw & rej_p;
  wire do_rep_aw = in_aw & rx_auth_reply & ~rx_auth_reject;
  wire do_rep_rw = in_rw & rx_auth_reply & ~rx_auth_reject;
  wire busy_ev   = rx_auth_reject | rx_auth_reply;
  wire do_rt_aw  = in_aw & retry_exp & ~busy_ev;
  wire do_rt_rw  = in_rw & retry_exp & ~busy_ev;
  wire do_rjw    = in_rjw & rejw_exp;
  wire do_grace  = in_auth & grace_exp;
  wire do_inv_au = in_auth & ev_inv;
  wire do_rq_au  = in_auth & reauth_req;
  wire do_inv_rw = in_rw & ev_inv & ~busy_ev;
  wire go_reauth = do_grace | do_inv_au | do_rq_au;
  wire any_rej   = do_np_aw | do_np_rw | do_p_aw | do_p_rw;
  wire any_rep   = do_rep_aw | do_rep_rw;
  wire any_stop  = do_np_rw | do_p_rw;

  // Timer controls; start and terminated states hold every timer off
  // Clear beats load in the timer, so Start must let the command load it
  wire retry_clr  = any_rej | any_rep | (in_start & ~do_cmd)
                  | in_term;
  wire retry_ld_a = do_cmd | do_rt_aw;
  wire retry_ld_r = go_reauth | do_rt_rw;
  wire [SEC_W-1:0] retry_val = retry_ld_a ? cfg_auth_wait_s
                                          : cfg_reauth_wait_s;
  wire rejw_ld    = do_np_aw | do_np_rw;
  wire grace_clr  = do_inv_au | do_rq_au | in_start | in_term;
  // Grace fires this long before key expiry; a short life fires on the next tick
  wire [SEC_W-1:0] grace_val = (reply_ak_life > cfg_grace_s)
                             ? SEC_W'(reply_ak_life - cfg_grace_s)
                             : '0;

  // Key machine event vectors
  wire [NTEK-1:0] blame = sid_onehot(inv_src_valid, inv_src_id);
  wire [NTEK-1:0] stop_d = any_stop ? tek_active_q
                         : do_rep_rw ? (tek_active_q & ~reply_said_list)
                         : '0;
  wire [NTEK-1:0] comp_d = do_rep_rw ? (tek_active_q & reply_said_list)
                                     : '0;
  wire [NTEK-1:0] auth_d = do_rep_aw ? reply_said_list : '0;
  wire [NTEK-1:0] pend_d = (do_inv_au | do_inv_rw) ? blame : '0;

  tafs_tick_div #(
    .TICK_CYC (TICK_CYC)
  ) u_tick (
    .clk_sys (clk_sys),
    .rst     (rst),
    .tick_q  (tick)
  );

  tafs_timer #(.W(SEC_W)) u_retry (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .tick     (tick),
    .clr      (retry_clr),
    .load     (retry_ld_a | retry_ld_r),
    .load_val (retry_val),
    .run_q    (retry_run),
    .exp_q    (retry_exp)
  );

  tafs_timer #(.W(SEC_W)) u_rejw (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .tick     (tick),
    .clr      (in_start | in_term),
    .load     (rejw_ld),
    .load_val (cfg_reject_wait_s),
    .run_q    (rejw_run),
    .exp_q    (rejw_exp)
  );

  tafs_timer #(.W(SEC_W)) u_grace (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .tick     (tick),
    .clr      (grace_clr),
    .load     (any_rep),
    .load_val (grace_val),
    .run_q    (grace_run),
    .exp_q    (grace_exp)
  );

  // Next state; anything not listed leaves the state alone
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      TAFS_START:
        if (do_cmd)
          state_d = TAFS_AUTH_WAIT;
      TAFS_AUTH_WAIT:
        if (do_p_aw)
          state_d = TAFS_TERMINATED;
        else if (do_np_aw)
          state_d = TAFS_REJECT_WT;
        else if (do_rep_aw)
          state_d = TAFS_AUTHORIZED;
      TAFS_AUTHORIZED:
        if (go_reauth)
          state_d = TAFS_REAUTH_WT;
      TAFS_REAUTH_WT:
        if (do_p_rw)
          state_d = TAFS_TERMINATED;
        else if (do_np_rw)
          state_d = TAFS_REJECT_WT;
        else if (do_rep_rw)
          state_d = TAFS_AUTHORIZED;
      TAFS_REJECT_WT:
        if (do_rjw)
          state_d = TAFS_START;
      TAFS_TERMINATED:
        state_d = TAFS_TERMINATED;
      default:
        state_d = TAFS_START;
    endcase
  end

  // State, messages and traffic gate
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q       <= TAFS_START;
      tx_mfr_info_q <= 1'b0;
      tx_auth_req_q <= 1'b0;
      traffic_en_q  <= 1'b0;
      trap_term_q   <= 1'b0;
      mgmt_resp_q   <= 1'b0;
    end
    else
    begin
      state_q       <= state_d;
      tx_mfr_info_q <= do_cmd | do_rt_aw;
      tx_auth_req_q <= do_cmd | do_rt_aw | do_rt_rw | go_reauth;
      // Forwarding opens on authorization and closes for good on perm reject
      traffic_en_q  <= (traffic_en_q | any_rep) & ~(do_p_aw | do_p_rw);
      trap_term_q   <= do_p_aw | do_p_rw;
      mgmt_resp_q   <= rx_mgmt_msg;
    end
  end

  // Key record and key machine events
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ak_q             <= '0;
      tek_active_q     <= '0;
      tek_stop_q       <= '0;
      tek_authorized_q <= '0;
      tek_pend_q       <= '0;
      tek_comp_q       <= '0;
    end
    else
    begin
      if (any_rep)
        ak_q <= reply_ak;
      // Stopped machines drop out; their keys are purged outside
      tek_active_q     <= (tek_active_q | auth_d) & ~stop_d;
      tek_stop_q       <= stop_d;
      tek_authorized_q <= auth_d;
      tek_pend_q       <= pend_d;
      tek_comp_q       <= comp_d;
    end
  end

  a_cmd_start: assert property (@(posedge clk_sys) disable iff (rst)
    in_start && rx_auth_cmd |=> state_q == TAFS_AUTH_WAIT
      && tx_mfr_info_q && tx_auth_req_q && retry_run)
    else $error("command in start not handled");

  a_np_rej_aw: assert property (@(posedge clk_sys) disable iff (rst)
    in_aw && rx_auth_reject && !reject_perm
      |=> state_q == TAFS_REJECT_WT && !retry_run && rejw_run)
    else $error("non-permanent reject in auth wait mishandled");

  a_np_rej_rw: assert property (@(posedge clk_sys) disable iff (rst)
    in_rw && rx_auth_reject && !reject_perm
      |=> state_q == TAFS_REJECT_WT && tek_stop_q == $past(tek_active_q)
        && tek_active_q == '0)
    else $error("non-permanent reject in reauth wait mishandled");

  a_perm_rej: assert property (@(posedge clk_sys) disable iff (rst)
    (in_aw || in_rw) && rx_auth_reject && reject_perm
      |=> state_q == TAFS_TERMINATED && !traffic_en_q && trap_term_q)
    else $error("permanent reject did not terminate");

  a_term_hold: assert property (@(posedge clk_sys) disable iff (rst)
    in_term && rx_mgmt_msg |=> in_term && !traffic_en_q && mgmt_resp_q)
    else $error("terminated state leaked traffic or dropped management");

  a_reply_aw: assert property (@(posedge clk_sys) disable iff (rst)
    in_aw && rx_auth_reply && !rx_auth_reject
      |=> state_q == TAFS_AUTHORIZED && grace_run
        && tek_authorized_q == $past(reply_said_list))
    else $error("reply in auth wait mishandled");

  a_retry_aw: assert property (@(posedge clk_sys) disable iff (rst)
    in_aw && retry_exp && !rx_auth_reject && !rx_auth_reply
      |=> in_aw && tx_mfr_info_q && tx_auth_req_q)
    else $error("auth wait retry did not resend both");

  a_retry_rw: assert property (@(posedge clk_sys) disable iff (rst)
    in_rw && retry_exp && !rx_auth_reject && !rx_auth_reply
      |=> in_rw && !tx_mfr_info_q && tx_auth_req_q)
    else $error("reauth wait retry sent wrong messages");

  a_ignore_ev: assert property (@(posedge clk_sys) disable iff (rst)
    in_auth && !grace_exp && !ev_inv && !reauth_req
      |=> in_auth && !tx_auth_req_q && $stable(ak_q))
    else $error("ignored event changed authorized state");
endmodule

// ===== core/tafs_map.svh
// Purpose: Named constants for the terminal authorization state machine
// Assumes: 50 MHz system clock, timeouts counted in whole seconds
// Notes:   Definitions only; included by bare name
`ifndef TAFS_MAP_SVH
`define TAFS_MAP_SVH

// System clock period in ns (50 MHz)
`define TAFS_CLK_PERIOD_NS 20
// Timer tick period in seconds, and ns per second
`define TAFS_TICK_PERIOD_S 1
`define TAFS_NS_PER_S      1000000000
// Default width of second counters and timeout settings
`define TAFS_SEC_W         16
// Default number of traffic-key machines (one per SAID slot)
`define TAFS_NTEK          4
// Default width of the recorded authorization key
`define TAFS_AK_W          128
// Timer reaches its last second at this count
`define TAFS_LAST_SEC      1

`endif

// ===== core/tafs_pkg.sv
// Purpose: Types shared by the authorization state machine files
// Assumes: Nothing beyond SystemVerilog packages
// Notes:   Gray codes along Start, Auth Wait, Authorized, Reauth Wait
package tafs_pkg;

  // Six states; two 3-bit codes are illegal
  typedef enum logic [2:0] {
    TAFS_START      = 3'h0,
    TAFS_AUTH_WAIT  = 3'h1,
    TAFS_AUTHORIZED = 3'h3,
    TAFS_REAUTH_WT  = 3'h2,
    TAFS_REJECT_WT  = 3'h6,
    TAFS_TERMINATED = 3'h7
  } tafs_state_t;

endpackage

// ===== core/tafs_tick_div.sv
// Purpose: One-cycle enable pulse once per second from the system clock
// Assumes: Single clock domain, synchronous active-high reset
// Notes:   TICK_CYC may be shortened in simulation
`timescale 1ns/1ns
`include "tafs_map.svh"
module tafs_tick_div #(
  parameter int unsigned TICK_CYC =
    (`TAFS_TICK_PERIOD_S * `TAFS_NS_PER_S) / `TAFS_CLK_PERIOD_NS
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  output logic      tick_q
);
  import tafs_pkg::*;

  logic [31:0] cnt_q;
  wire         wrap = (cnt_q == 32'(TICK_CYC - 1));

  // Free-running divider; tick is registered, so it follows the last cycle of each period by one clock
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= wrap ? '0 : cnt_q + 32'h1;
      tick_q <= wrap;
    end
  end
endmodule

// ===== core/tafs_timer.sv
// Purpose: Second-resolution countdown timer with load and clear
// Assumes: tick is a one-cycle enable, once per second
// Notes:   Clear beats load; a zero load expires on the next tick
`timescale 1ns/1ns
`include "tafs_map.svh"
module tafs_timer #(
  parameter int W = `TAFS_SEC_W
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         tick,
  input  wire logic         clr,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              run_q,
  output logic              exp_q
);
  import tafs_pkg::*;

  logic [W-1:0] cnt_q;
  wire          last = (cnt_q <= W'(`TAFS_LAST_SEC));

  // Count down on each tick; signal expiry as it reaches zero
  always_ff @(posedge clk_sys)
  begin
    if (rst || clr)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end
    else if (load)
    begin
      cnt_q <= load_val;
      run_q <= 1'b1;
      exp_q <= 1'b0;
    end
    else
    begin
      exp_q <= run_q && tick && last;
      if (run_q && tick)
      begin
        cnt_q <= last ? '0 : cnt_q - W'(`TAFS_LAST_SEC);
        run_q <= !last;
      end
    end
  end
endmodule

// ===== verification/tafs_ap_model.sv
// Purpose: Access point side: answers each authorization request except in mode 0
// Assumes: Requests arrive as one-cycle pulses on clk_sys
// Notes:   Idle reply fields toggle, so stale values never look valid
`timescale 1ns/1ns
module tafs_ap_model (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         tx_auth_req,
  input  wire logic [1:0]   mode,
  input  wire logic [3:0]   lat,
  input  wire logic [3:0]   list,
  input  wire logic [127:0] ak,
  input  wire logic [15:0]  life,
  output logic              rx_auth_reply,
  output logic              rx_auth_reject,
  output logic              reject_perm,
  output logic [127:0]      reply_ak,
  output logic [15:0]       reply_ak_life,
  output logic [3:0]        reply_said_list
);
  logic [4:0] cnt_q;

  initial {rx_auth_reply, rx_auth_reject, reject_perm, reply_ak,
    reply_ak_life, reply_said_list, cnt_q} = '0;

  // Mode 0 silent, 1 reply, 2 retry-later reject, 3 permanent reject
  always @(posedge clk_sys)
  begin
    rx_auth_reply <= 1'b0;
    rx_auth_reject <= 1'b0;
    reject_perm <= ~reject_perm;
    reply_ak <= ~reply_ak;
    reply_ak_life <= ~reply_ak_life;
    reply_said_list <= ~reply_said_list;
    if (rst)
      cnt_q <= 5'h0;
    else if (tx_auth_req && mode != 2'h0)
      cnt_q <= {1'b0, lat} + 5'h1; // Answer delay is lat plus one cycle, drawn at random by the bench on each ans call
    else if (cnt_q != 5'h0)
    begin
      cnt_q <= cnt_q - 5'h1;
      if (cnt_q == 5'h1)
      begin
        rx_auth_reply <= (mode == 2'h1);
        rx_auth_reject <= mode[1];
        reject_perm <= (mode == 2'h3);
        reply_ak <= ak;
        reply_ak_life <= life;
        reply_said_list <= list;
      end
    end
  end
endmodule

// ===== verification/test_terminal_authorization_fsm.sv
// Purpose: Self-checking bench for the authorization state machine
// Assumes: One second shortened to TC clock cycles
// Notes:   Output pulses are gathered on the falling edge
`timescale 1ns/1ns
module test_terminal_authorization_fsm;
  import tafs_pkg::*;
  localparam int TC = 10;
  logic         clk_sys = 1'b0;
  logic         rst = 1'b1;
  logic [4:0]   evs = 5'h0;
  logic         src_vld = 1'b0;
  logic [1:0]   src_id = 2'h0;
  logic [1:0]   mode = 2'h0;
  logic [3:0]   lat = 4'h1;
  logic [3:0]   list = 4'h1;
  logic [127:0] ak_v = '0;
  logic [15:0]  life = 16'h1f4;
  logic         rep, rej, perm;
  logic [127:0] r_ak;
  logic [15:0]  r_life;
  logic [3:0]   r_list;
  tafs_state_t  state_q;
  logic         tx_mfr_info_q, tx_auth_req_q, mgmt_resp_q;
  logic         traffic_en_q, trap_term_q;
  logic [127:0] ak_q;
  logic [3:0]   tek_active_q, tek_stop_q, tek_authorized_q;
  logic [3:0]   tek_pend_q, tek_comp_q;
  logic [3:0]   acc_stop, acc_auth, acc_pend, acc_comp, act, l1;
  int           n_req, n_mfr, n_trap, n_mgmt, w;
  int           err_total = 0;
  int           total_checks = 0;
  int           seed = 32'h6707fd88;

  tafs_ap_model ap (.clk_sys(clk_sys), .rst(rst), .tx_auth_req(tx_auth_req_q),
    .mode(mode), .lat(lat), .list(list), .ak(ak_v), .life(life),
    .rx_auth_reply(rep), .rx_auth_reject(rej), .reject_perm(perm),
    .reply_ak(r_ak), .reply_ak_life(r_life), .reply_said_list(r_list));

  tafs_auth_fsm #(.TICK_CYC(TC)) uut (.clk_sys(clk_sys), .rst(rst),
    .rx_auth_cmd(evs[0]), .rx_auth_reject(rej), .reject_perm(perm),
    .rx_auth_reply(rep), .reply_ak(r_ak), .reply_ak_life(r_life),
    .reply_said_list(r_list), .rx_auth_invalid(evs[2]),
    .tek_auth_fail(evs[1]), .inv_src_valid(src_vld), .inv_src_id(src_id),
    .reauth_req(evs[3]), .rx_mgmt_msg(evs[4]),
    .cfg_auth_wait_s(16'h2), .cfg_reauth_wait_s(16'h2),
    .cfg_grace_s(16'h3), .cfg_reject_wait_s(16'h3),
    .state_q(state_q), .tx_mfr_info_q(tx_mfr_info_q),
    .tx_auth_req_q(tx_auth_req_q), .mgmt_resp_q(mgmt_resp_q),
    .traffic_en_q(traffic_en_q), .trap_term_q(trap_term_q), .ak_q(ak_q),
    .tek_active_q(tek_active_q), .tek_stop_q(tek_stop_q),
    .tek_authorized_q(tek_authorized_q), .tek_pend_q(tek_pend_q),
    .tek_comp_q(tek_comp_q));

  always #10 clk_sys = ~clk_sys;

  // Gather pulses mid-cycle, away from the launching edge
  always @(negedge clk_sys)
  begin
    acc_stop = acc_stop | tek_stop_q;
    acc_auth = acc_auth | tek_authorized_q;
    acc_pend = acc_pend | tek_pend_q;
    acc_comp = acc_comp | tek_comp_q;
    n_req += int'(tx_auth_req_q === 1'b1);
    n_mfr += int'(tx_mfr_info_q === 1'b1);
    n_trap += int'(trap_term_q === 1'b1);
    n_mgmt += int'(mgmt_resp_q === 1'b1);
  end

  task automatic chk(input string n, input logic [127:0] s,
                     input logic [127:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic clr();
    {acc_stop, acc_auth, acc_pend, acc_comp} = '0;
    {n_req, n_mfr, n_trap, n_mgmt} = '0;
  endtask

  // Window for an N second timer seen from its loading edge
  function automatic logic gap_ok(input int g, input int n);
    return g >= (n - 1) * TC && g <= n * TC + 4;
  endfunction

  task automatic fire(input logic [4:0] e);
    @(posedge clk_sys);
    evs <= e;
    @(posedge clk_sys);
    evs <= 5'h0;
  endtask

  task automatic ans(input logic [1:0] m, input logic [3:0] l,
                     input logic [15:0] lf);
    mode <= m;
    list <= l;
    lf = lf;
    life <= lf;
    lat <= 4'($random(seed) & 3);
    ak_v <= {4{32'($random(seed))}};
  endtask

  task automatic wait_st(input tafs_state_t s, input int lim);
    w = 0;
    do
    begin
      @(posedge clk_sys);
      w++;
    end while (state_q !== s && w < lim);
    chk("state", state_q, s);
  endtask

  // Edges already spent since the timer load are passed in as w0
  task automatic wait_req(input int w0);
    w = w0;
    do
    begin
      @(posedge clk_sys);
      w++;
    end while (n_req == 0 && w < 100);
  endtask

  task automatic final_report();
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard, far beyond the longest sequence
  initial
  begin
    #400000;
    err_total++;
    final_report();
  end

  // Main sequence
  initial
  begin
    clr();
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    chk("reset", {state_q, traffic_en_q, tek_active_q}, '0);
    chk("reset_ak", ak_q, '0);
    fire(5'h0e);
    wait_st(TAFS_START, 2);
    chk("req", n_req, 0);
    fire(5'h01);
    wait_st(TAFS_AUTH_WAIT, 2);
    chk("cmd", {n_req, n_mfr}, {32'd1, 32'd1});
    clr();
    wait_req(0);
    chk("retry", {gap_ok(w, 2), n_mfr}, {1'b1, 32'd1});
    l1 = 4'($random(seed)) | 4'h3;
    ans(2'h1, l1, 16'h1f4);
    clr();
    wait_st(TAFS_AUTHORIZED, 60);
    chk("reply", {acc_auth, tek_active_q, traffic_en_q}, {l1, l1, 1'b1});
    chk("ak", ak_q, ak_v);
    ans(2'h0, l1, 16'h1f4);
    clr();
    fire(5'h08);
    wait_st(TAFS_REAUTH_WT, 2);
    chk("reauth", {n_req, n_mfr}, {32'd1, 32'd0});
    src_vld <= 1'b1;
    src_id <= 2'($random(seed));
    fire(5'h02);
    wait_st(TAFS_REAUTH_WT, 2);
    chk("pend", acc_pend, 4'h1 << src_id);
    clr();
    wait_req(4);
    chk("reretry", {gap_ok(w, 2), n_mfr}, {1'b1, 32'd0});
    act = l1 & 4'he;
    ans(2'h1, act, 16'h4);
    clr();
    wait_st(TAFS_AUTHORIZED, 60);
    chk("comp", {acc_comp, acc_stop}, {act, 4'h1});
    chk("active", tek_active_q, act);
    ans(2'h0, act, 16'h1f4);
    clr();
    wait_st(TAFS_REAUTH_WT, 3 * TC);
    chk("grace", {gap_ok(w, 1), n_req, n_mfr}, {1'b1, 32'd1, 32'd0});
    l1 = 4'($random(seed)) | 4'h3; // Keeps one machine active for the stop
    act = act & l1;
    ans(2'h1, l1, 16'h1f4);
    wait_st(TAFS_AUTHORIZED, 60);
    ans(2'h2, l1, 16'h1f4);
    clr();
    src_id <= 2'($random(seed));
    fire(5'h04);
    wait_st(TAFS_REAUTH_WT, 2);
    chk("inval", {acc_pend, n_req}, {4'h1 << src_id, 32'd1});
    clr();
    wait_st(TAFS_REJECT_WT, 30);
    chk("stop", {acc_stop, tek_active_q}, {act, 4'h0});
    wait_st(TAFS_START, 5 * TC);
    chk("rejwait", gap_ok(w, 3), 1'b1);
    clr();
    fire(5'h01);
    wait_st(TAFS_REJECT_WT, 12);
    chk("nostop", acc_stop, 4'h0);
    wait_st(TAFS_START, 5 * TC);
    l1 = 4'($random(seed)) | 4'h8;
    ans(2'h1, l1, 16'h1f4);
    fire(5'h01);
    wait_st(TAFS_AUTHORIZED, 12);
    ans(2'h3, l1, 16'h1f4);
    clr();
    fire(5'h08);
    wait_st(TAFS_TERMINATED, 12);
    chk("perm", {acc_stop, traffic_en_q, n_trap}, {l1, 1'b0, 32'd1});
    clr();
    fire(5'h11);
    wait_st(TAFS_TERMINATED, 2);
    chk("mgmt", {n_mgmt, n_req}, {32'd1, 32'd0});
    rst <= 1'b1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    clr();
    fire(5'h01);
    wait_st(TAFS_TERMINATED, 12);
    chk("perm1", {traffic_en_q, n_trap}, {1'b0, 32'd1});
    final_report();
  end
endmodule
